// ===== verilog/fls_host.sv
//
// Notes on behaviour
// - buffered program: count minus one, N address/data pairs, then confirm.
// - with both suspended, resume the program before the erase.
// - mask status bits 15 to 8 and bit 0 when polling.
// - buffer status bit 7 low means buffered program refused; reissue it.
// - mask partition word bits 15 to 11 and 7 to 0 on read.
// - partition setup code goes on the low sixteen address lines.
// - both cycles of a two-cycle command use the same address.
//
`timescale 1ns/10ps
module fls_host
	import fls_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic [15:0]      dq_in,
	output fls_pkg::fls_pins_t    pins
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	fls_state_t        state;
	fls_kind_t         kind;
	logic [1:0]        step;
	logic [7:0]        code;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] eff_addr;
	logic [ADDR_W-1:0] susp_addr;
	logic [15:0]       wdata_reg;
	logic [15:0]       rd_data;
	logic [2:0]        ctrl;
	logic              tmr_load;
	logic [TMR_W-1:0]  tmr_val;
	logic              tmr_done;
	logic              susp_valid;
	logic              refused;
	logic              redirected;
	logic              buf_retry;
	logic              hit;
	logic [31:0]       rd_mux;
	logic              wr_acc;
	logic              start;
	logic              redirect;
	logic              cyc_wr;
	logic              cyc_last;
	logic [15:0]       cyc_data;
	logic              poll_susp;
	fls_kind_t         new_kind;
	logic [7:0]        new_code;

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	// one wait state: pready rises one cycle into the access phase
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			if (psel && penable && !pready) begin
				pready  <= 1'b1;
				pslverr <= !hit;
				prdata  <= rd_mux;
			end
		end
	end

	// read decode; unmapped offsets answer zero with an error
	always_comb begin
		hit    = 1'b1;
		rd_mux = '0;
		unique case (paddr)
			OFF_CMD:     rd_mux = {21'h0, kind, code};
			OFF_ADDR:    rd_mux = {10'h0, addr_reg};
			OFF_WDATA:   rd_mux = {16'h0, wdata_reg};
			OFF_CTRL:    rd_mux = {29'h0, ctrl};
			OFF_STAT:    rd_mux = {27'h0, buf_retry, susp_valid, redirected, refused,
				state != S_IDLE};
			OFF_RDATA:   rd_mux = {16'h0, rd_data};
			OFF_SR_VIEW: rd_mux = {16'h0, rd_data & SR_VIEW_MASK};
			OFF_PS_VIEW: rd_mux = {16'h0, rd_data & PS_VIEW_MASK};
			default:     hit = 1'b0;
		endcase
	end

	// writes take effect only at the edge that completes the transfer
	assign wr_acc   = psel && penable && pready && pwrite && hit;
	assign start    = wr_acc && (paddr == OFF_CMD);
	assign new_kind = fls_kind_t'(pwdata[CMD_KIND_LSB +: 3]);
	assign new_code = pwdata[CMD_CODE_LSB +: 8];
	// a resume while a program suspend is on record goes to that partition
	assign redirect = (new_kind == K_WR1) && (new_code == CODE_RESUME) && susp_valid;

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_reg  <= '0;
			wdata_reg <= '0;
			ctrl      <= CTRL_RESET;
		end else if (wr_acc) begin
			unique case (paddr)
				OFF_ADDR:  addr_reg  <= pwdata[ADDR_W-1:0];
				OFF_WDATA: wdata_reg <= pwdata[15:0];
				OFF_CTRL:  ctrl      <= pwdata[2:0];
				default:   ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// bus cycle plan for the current step
	// ----------------------------------------------------------------
	always_comb begin
		cyc_wr   = 1'b1;
		cyc_last = 1'b1;
		cyc_data = {8'h00, code};
		unique case (kind)
			K_WR1: ;
			K_WR2: begin
				cyc_last = (step == 2'd1);
				if (step != 2'd0) cyc_data = wdata_reg;
			end
			K_WRRD: begin
				cyc_last = (step == 2'd1);
				cyc_wr   = (step == 2'd0);
			end
			K_RD:   cyc_wr = 1'b0;
			K_DATA: cyc_data = wdata_reg;
			K_PSETUP: begin
				cyc_last = (step == 2'd1);
				cyc_data = {8'h00, (step == 2'd0) ? CODE_LOCK_SETUP : CODE_PS_CONFIRM};
			end
			K_BUFPGM: begin
				cyc_last = (step == 2'd2);
				cyc_wr   = (step != 2'd1);
				cyc_data = (step == 2'd2) ? wdata_reg : {8'h00, CODE_BUF_PGM};
			end
			K_POLL: begin
				cyc_last = (step == 2'd1);
				cyc_wr   = (step == 2'd0);
				cyc_data = {8'h00, CODE_STATUS_READ};
			end
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	fls_tmr #(
		.W (TMR_W)
	) u_tmr (
		.clk   (clk),
		.rst_b (rst_b),
		.load  (tmr_load),
		.val   (tmr_val),
		.done  (tmr_done)
	);

	// eff_addr is latched once per command and reused in every cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state    <= S_RST;
			kind     <= K_WR1;
			code     <= '0;
			step     <= '0;
			eff_addr <= '0;
			rd_data  <= '0;
			tmr_load <= 1'b0;
			tmr_val  <= '0;
		end else begin
			tmr_load <= 1'b0;
			if (ctrl[CTRL_RST_BIT]) begin
				// flash held in reset: keep reloading the recovery time
				state    <= S_RST;
				tmr_load <= 1'b1;
				tmr_val  <= CYC_RSTREC;
			end else begin
				unique case (state)
					S_IDLE: if (start) begin
						kind  <= new_kind;
						code  <= new_code;
						step  <= '0;
						state <= S_DEC;
						if (redirect) begin
							eff_addr <= susp_addr;
						end else if (new_kind == K_PSETUP) begin
							eff_addr <= {addr_reg[ADDR_W-1:16], wdata_reg};
						end else begin
							eff_addr <= addr_reg;
						end
					end
					S_DEC: begin
						tmr_load <= 1'b1;
						if (cyc_wr) begin
							tmr_val <= CYC_WSETUP;
							state   <= S_WSET;
						end else begin
							tmr_val <= CYC_ACC;
							state   <= S_RLOW;
						end
					end
					S_WSET: if (tmr_done) begin
						tmr_load <= 1'b1;
						tmr_val  <= CYC_WLOW;
						state    <= S_WLOW;
					end
					S_WLOW: if (tmr_done) begin
						tmr_load <= 1'b1;
						tmr_val  <= CYC_WREC;
						state    <= S_WREC;
					end
					S_WREC: if (tmr_done) begin
						if (cyc_last) begin
							state <= S_IDLE;
						end else begin
							step  <= step + 2'd1;
							state <= S_DEC;
						end
					end
					S_RLOW: if (tmr_done) begin
						rd_data  <= dq_in;
						tmr_load <= 1'b1;
						tmr_val  <= CYC_RREC;
						state    <= S_RREC;
					end
					S_RREC: if (tmr_done) begin
						if (kind == K_POLL && !rd_data[SR_READY_BIT]) begin
							state <= S_DEC;
						end else if (kind == K_BUFPGM && !rd_data[XSR_AVAIL_BIT]) begin
							step  <= '0;
							state <= S_DEC;
						end else if (cyc_last) begin
							state <= S_IDLE;
						end else begin
							step  <= step + 2'd1;
							state <= S_DEC;
						end
					end
					S_RST: if (tmr_done) state <= S_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// sticky status and suspend tracking
	// ----------------------------------------------------------------
	// a poll that ends ready with the program-suspend bit records the
	// partition, so a later resume can serve the program first
	assign poll_susp = (state == S_RREC) && tmr_done && (kind == K_POLL)
		&& rd_data[SR_READY_BIT] && rd_data[SR_PGM_SUSP_BIT];

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			susp_valid <= 1'b0;
			susp_addr  <= '0;
		end else if (poll_susp) begin
			susp_valid <= 1'b1;
			susp_addr  <= eff_addr;
		end else if (start && state == S_IDLE && redirect) begin
			susp_valid <= 1'b0;
		end
	end

	// write-one-to-clear; a new event in the same cycle wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			refused    <= 1'b0;
			redirected <= 1'b0;
			buf_retry  <= 1'b0;
		end else begin
			if (wr_acc && paddr == OFF_STAT) begin
				if (pwdata[STAT_REFUSED_BIT]) refused    <= 1'b0;
				if (pwdata[STAT_REDIR_BIT])   redirected <= 1'b0;
				if (pwdata[STAT_RETRY_BIT])   buf_retry  <= 1'b0;
			end
			if (start && state != S_IDLE) refused <= 1'b1;
			if (start && state == S_IDLE && redirect) redirected <= 1'b1;
			if (state == S_RREC && tmr_done && kind == K_BUFPGM && !rd_data[XSR_AVAIL_BIT])
				buf_retry <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// flash pins
	// ----------------------------------------------------------------
	// strobe and select rise together while data still drives, so the
	// flash latches stable data whichever edge it sees first
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pins        <= '0;
			pins.ce_b   <= 1'b1;
			pins.we_b   <= 1'b1;
			pins.oe_b   <= 1'b1;
		end else begin
			pins.rst_b  <= !ctrl[CTRL_RST_BIT];
			pins.wp_b   <= ctrl[CTRL_WP_BIT];
			pins.vpp_en <= ctrl[CTRL_VPP_BIT];
			pins.ce_b   <= !(state == S_WSET || state == S_WLOW || state == S_RLOW);
			pins.we_b   <= (state != S_WLOW);
			pins.oe_b   <= (state != S_RLOW);
			pins.dq_oe  <= (state == S_WSET || state == S_WLOW || state == S_WREC);
			pins.addr   <= eff_addr;
			pins.dq_out <= cyc_data;
		end
	end
endmodule

// ===== verilog/fls_pkg.sv
package fls_pkg;

	// ----------------------------------------------------------------
	// clock and pin timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 8000;            // 125 MHz
	localparam int T_WSETUP_NS   = 10;              // address/data before strobe
	localparam int T_WLOW_NS     = 60;              // write strobe low
	localparam int T_WREC_NS     = 30;              // data hold and strobe high
	localparam int T_ACC_NS      = 90;              // read access
	localparam int T_RREC_NS     = 20;              // output float after read
	localparam int T_RSTREC_NS   = 150;             // reset high to first access

	// least times round up, never below one cycle
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int TMR_W = 5;
	localparam logic [TMR_W-1:0] CYC_WSETUP = TMR_W'(ns_to_cyc(T_WSETUP_NS));
	localparam logic [TMR_W-1:0] CYC_WLOW   = TMR_W'(ns_to_cyc(T_WLOW_NS));
	localparam logic [TMR_W-1:0] CYC_WREC   = TMR_W'(ns_to_cyc(T_WREC_NS));
	localparam logic [TMR_W-1:0] CYC_ACC    = TMR_W'(ns_to_cyc(T_ACC_NS));
	localparam logic [TMR_W-1:0] CYC_RREC   = TMR_W'(ns_to_cyc(T_RREC_NS));
	localparam logic [TMR_W-1:0] CYC_RSTREC = TMR_W'(ns_to_cyc(T_RSTREC_NS));

	// ----------------------------------------------------------------
	// register map (byte offsets)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CMD     = 8'h00;
	localparam logic [7:0] OFF_ADDR    = 8'h04;
	localparam logic [7:0] OFF_WDATA   = 8'h08;
	localparam logic [7:0] OFF_CTRL    = 8'h0C;
	localparam logic [7:0] OFF_STAT    = 8'h10;
	localparam logic [7:0] OFF_RDATA   = 8'h14;
	localparam logic [7:0] OFF_SR_VIEW = 8'h18;
	localparam logic [7:0] OFF_PS_VIEW = 8'h1C;

	localparam int CMD_CODE_LSB = 0;
	localparam int CMD_KIND_LSB = 8;
	localparam int CTRL_RST_BIT = 0;
	localparam int CTRL_WP_BIT  = 1;
	localparam int CTRL_VPP_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h1;      // flash held in reset

	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_REFUSED_BIT = 1;
	localparam int STAT_REDIR_BIT   = 2;
	localparam int STAT_SUSP_BIT    = 3;
	localparam int STAT_RETRY_BIT   = 4;

	// ----------------------------------------------------------------
	// flash codes and status fields
	// ----------------------------------------------------------------
	localparam logic [7:0] CODE_STATUS_READ = 8'h70;
	localparam logic [7:0] CODE_BUF_PGM     = 8'hE8;
	localparam logic [7:0] CODE_LOCK_SETUP  = 8'h60;
	localparam logic [7:0] CODE_PS_CONFIRM  = 8'h04;
	localparam logic [7:0] CODE_RESUME      = 8'hD0;
	localparam int SR_READY_BIT     = 7;
	localparam int SR_PGM_SUSP_BIT  = 2;
	localparam int XSR_AVAIL_BIT    = 7;
	localparam logic [15:0] SR_VIEW_MASK = 16'h00FE;
	localparam logic [15:0] PS_VIEW_MASK = 16'h0700;

	localparam int ADDR_W = 22;

	typedef enum logic [2:0] {
		K_WR1    = 3'h0,   // write code
		K_WR2    = 3'h1,   // write code, then write data
		K_WRRD   = 3'h2,   // write code, then read
		K_RD     = 3'h3,   // single read
		K_DATA   = 3'h4,   // single write of data
		K_PSETUP = 3'h5,   // partition setup, code on low address
		K_BUFPGM = 3'h6,   // buffered program start with availability retry
		K_POLL   = 3'h7    // status poll until ready
	} fls_kind_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_WSET = 3'b001,
		S_WLOW = 3'b011,
		S_WREC = 3'b010,
		S_DEC  = 3'b110,
		S_RLOW = 3'b111,
		S_RREC = 3'b101,
		S_RST  = 3'b100
	} fls_state_t;

	typedef struct packed {
		logic              rst_b;
		logic              wp_b;
		logic              vpp_en;
		logic              ce_b;
		logic              we_b;
		logic              oe_b;
		logic              dq_oe;
		logic [ADDR_W-1:0] addr;
		logic [15:0]       dq_out;
	} fls_pins_t;

endpackage

// ===== verilog/fls_tmr.sv
`timescale 1ns/10ps
module fls_tmr #(
	parameter int W = 5
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         load,
	input  wire logic [W-1:0] val,
	output logic              done
);
	logic [W-1:0] cnt;

	// ----------------------------------------------------------------
	// phase down-counter
	// ----------------------------------------------------------------
	// reload wins over counting so a phase always gets its full length
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= '0;
		end else if (load) begin
			cnt <= val;
		end else if (cnt != '0) begin
			cnt <= cnt - 1'b1;
		end
	end

	// done is masked during load so a stale zero never ends a phase
	assign done = (cnt == '0) && !load;
endmodule

// ===== dv/fls_host_chk_sva.sv
`timescale 1ns/10ps
// ----------------------------------------
// port checker for the flash host
// ----------------------------------------
module fls_host_chk (
	input wire logic               clk,
	input wire logic               rst_b,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic [7:0]         paddr,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire fls_pkg::fls_pins_t pins
);
	import fls_pkg::*;
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("pready not one cycle after access start");
	a_err_unmapped: assert property (pready && paddr > 8'h1C |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_strobes_rise: assert property ($rose(pins.we_b) |-> $rose(pins.ce_b))
		else $error("write strobe and select rose apart");
	a_wdata_held: assert property ($rose(pins.we_b) |-> pins.dq_oe[*4])
		else $error("write data released too early");
	a_we_low_len: assert property ($fell(pins.we_b) |-> (!pins.we_b && !pins.ce_b)[*8])
		else $error("write strobe low too short");
	a_addr_stable: assert property (!pins.ce_b && $past(pins.ce_b) == 1'b0 |-> $stable(pins.addr))
		else $error("address moved inside a bus cycle");
	a_no_contend: assert property (!pins.oe_b |-> !pins.dq_oe && pins.we_b)
		else $error("host drives data during a read");
	a_read_len: assert property ($fell(pins.oe_b) |-> (!pins.oe_b && !pins.ce_b)[*8])
		else $error("read strobe low too short");
	a_rst_recover: assert property ($rose(pins.rst_b) |-> pins.ce_b[*8])
		else $error("flash selected too soon after reset");

	c_refused: cover property (pready && pslverr);
	c_write: cover property ($rose(pins.we_b));
	c_read: cover property ($rose(pins.oe_b));
endmodule
bind fls_host fls_host_chk u_chk (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins));

// ===== dv/fls_flash_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// behavioural flash: locks, status, partition
// ----------------------------------------
module fls_flash_model #(
	parameter logic [15:0] MAKER_ID = 16'h3C5A   // arbitrary value
) (
	input  wire logic               clk,
	input  wire fls_pkg::fls_pins_t pins,
	output logic [15:0]             dq_f
);
	import fls_pkg::*;
	logic [1:0]  blk [128];   // lock-down, lock per block
	logic        dis [128];   // block was lock-down-disabled unlocked
	logic [7:0]  sr;
	logic [7:0]  first;       // pending first-cycle code
	logic [7:0]  c;
	logic [2:0]  partition_setup_word;
	logic [1:0]  mode;        // array, status, id, buffer status
	logic        avail;
	logic [1:0]  idp;         // partition of the last identifier command
	logic        wr_q;
	logic        wp_q;
	logic        lkd;
	logic [15:0] rd;
	logic [15:0] last;
	wire         wr_n = pins.ce_b | pins.we_b;
	wire  [6:0]  b    = pins.addr[21:15];

	// write decode on the clock after a strobe rises; locks follow the pin
	always @(posedge clk) begin
		wr_q <= wr_n;
		wp_q <= pins.wp_b;
		c = pins.dq_out[7:0];
		lkd = blk[b][1] && !pins.wp_b;
		if (!pins.rst_b) begin
			for (int i = 0; i < 128; i++) begin
				blk[i] = 2'b01;
				dis[i] = 1'b0;
			end
			sr <= 8'h80;
			partition_setup_word <= 3'b100;
			first <= 8'h00;
			mode <= 2'd0;
			avail <= 1'b1;
		end else if (pins.wp_b !== wp_q) begin
			for (int i = 0; i < 128; i++) begin
				if (blk[i][1] && pins.wp_b)
					blk[i][0] = !dis[i];
				else if (blk[i][1]) begin
					dis[i] = !blk[i][0];
					blk[i][0] = 1'b1;
				end
			end
		end else if (wr_n && !wr_q) begin
			mode <= 2'd1;
			first <= 8'h00;
			if (first == 8'h60) begin
				case (c)
					8'h01: if (!lkd) blk[b][0] = 1'b1;
					8'hD0: if (!lkd) blk[b][0] = 1'b0;
					8'h2F: if (!lkd) blk[b] = 2'b11;
					8'h04: partition_setup_word <= pins.addr[10:8];
					default: sr[5:4] <= 2'b11;
				endcase
			end else if (first == 8'h40 || first == 8'h10) begin
				if (!pins.vpp_en)
					sr[3] <= 1'b1;
				else if (blk[b][0])
					sr[1] <= 1'b1;
			end else if (first != 8'hE8) begin
				first <= c;
				case (c)
					8'h50: sr <= 8'h80;
					8'h90: begin
						mode <= 2'd2;
						idp <= pins.addr[21:20];
					end
					8'hE8: begin
						mode <= 2'd3;
						avail <= !avail;
						if (avail)
							first <= 8'h00;
					end
					// suspend marks both a program and an erase as held
					8'hB0: begin
						sr[2] <= 1'b1;
						sr[6] <= 1'b1;
					end
					// program resumes first, erase on the next resume
					8'hD0: if (sr[2]) sr[2] <= 1'b0; else sr[6] <= 1'b0;
					8'hC0: if (sr[6]) sr[5:4] <= 2'b11;
					8'h70, 8'h60, 8'h40, 8'h10: ;
					default: mode <= 2'd0;
				endcase
			end
		end
	end

	// reserved bits of the status and partition words read as ones so the host has to mask them
	always @* begin
		rd = pins.addr[15:0];
		case (mode)
			2'd1: rd = {8'hFF, sr | 8'h01};
			2'd3: rd = {8'h00, avail, 7'h00};
			2'd2: if (pins.addr[21:20] != idp)
				rd = 16'h0000;
			else case (pins.addr[7:0])
				8'h00: rd = MAKER_ID;
				8'h02: rd = {14'h0, blk[b]};
				8'h06: rd = {5'h1F, partition_setup_word, 8'hFF};
				default: rd = 16'h0000;
			endcase
			default: ;
		endcase
	end
	// released bus shows no stale value
	assign dq_f = (pins.rst_b && !pins.ce_b && !pins.oe_b) ? rd : ~last;
	always @(posedge clk)
		last <= dq_f;
endmodule

// ===== dv/fls_host_test.sv
`timescale 1ns/10ps
// ----------------------------------------
// self-checking bench for the flash host
// ----------------------------------------
module fls_host_test;
	import fls_pkg::*;
	localparam logic [15:0] MK = 16'h3C5A;   // arbitrary value
	logic        clk;
	logic        rst_b;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] dq_in;
	logic [15:0] dq_f;
	fls_pins_t   pins;
	logic [31:0] rd;
	logic        se;
	logic [21:0] ba;
	logic        wp;
	logic [14:0] off;
	int          err_total = 0;
	int          checked = 0;
	logic [7:0]  ops [7] = '{8'h2F, 8'hD0, 8'h00, 8'hD0, 8'h00, 8'h00, 8'h01};
	logic [1:0]  exps [7] = '{2'd3, 2'd3, 2'd3, 2'd2, 2'd3, 2'd2, 2'd3};

	always #4 clk = ~clk;
	// the data wire: host while enabled, else the flash side
	assign dq_in = pins.dq_oe ? pins.dq_out : dq_f;

	fls_host dut (
		.clk     (clk),
		.rst_b   (rst_b),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.paddr   (paddr),
		.pwdata  (pwdata),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.dq_in   (dq_in),
		.pins    (pins)
	);
	fls_flash_model #(.MAKER_ID(MK)) u_flash (.clk(clk), .pins(pins), .dq_f(dq_f));

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cmd(input logic [2:0] k, input logic [7:0] c, input logic [21:0] a,
		input logic [15:0] d);
		apb(1'b1, OFF_ADDR, {10'h0, a});
		apb(1'b1, OFF_WDATA, {16'h0, d});
		apb(1'b1, OFF_CMD, {21'h0, k, c});
		do
			apb(1'b0, OFF_STAT, 32'h0);
		while (rd[STAT_BUSY_BIT] !== 1'b0);
	endtask

	// engine needs its reset recovery before the next command
	task automatic ctrl(input logic [2:0] v);
		apb(1'b1, OFF_CTRL, {29'h0, v});
		repeat (int'(CYC_RSTREC) + 4) @(posedge clk);
	endtask

	task automatic sr_is(input logic [7:0] e);
		cmd(K_WRRD, CODE_STATUS_READ, ba, 16'h0);
		apb(1'b0, OFF_SR_VIEW, 32'h0);
		check(rd, {24'h0, e} & {16'h0, SR_VIEW_MASK});
		cmd(K_WR1, 8'h50, ba, 16'h0);
	endtask

	task automatic lk_is(input logic [1:0] e);
		cmd(K_WRRD, 8'h90, {ba[21:8], 8'h02}, 16'h0);
		apb(1'b0, OFF_RDATA, 32'h0);
		check(rd, {30'h0, e});
	endtask

	task automatic end_sim();
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		void'($urandom(32'hDEB5));
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, OFF_CTRL, 32'h0);
		check(rd, {29'h0, CTRL_RESET});
		// control reset bit still holds the flash in reset, so busy reads high
		apb(1'b0, OFF_STAT, 32'h0);
		check(rd, 32'h1);
		apb(1'b1, 8'h40, 32'hFFFF_FFFF);
		check({31'h0, se}, 32'h1);
		ctrl(3'h4);
		ba = {7'($urandom), 15'h0};
		lk_is(2'd1);
		cmd(K_WR2, 8'h40, ba | 22'($urandom_range(255)), 16'($urandom));
		sr_is(8'h82);
		cmd(K_WR2, CODE_LOCK_SETUP, ba, 16'h00D0);
		lk_is(2'd0);
		for (int i = 0; i < 4; i++) begin
			cmd(K_WR2, i[0] ? 8'h10 : 8'h40, ba | 22'($urandom_range(32767)), 16'($urandom));
			sr_is(8'h80);
		end
		ctrl(3'h0);
		cmd(K_WR2, 8'h40, ba, 16'($urandom));
		sr_is(8'h88);
		ctrl(3'h4);
		cmd(K_WR2, CODE_LOCK_SETUP, ba, 16'h0055);
		sr_is(8'hB0);
		// lock walk on one block, the pin toggled between commands
		wp = 1'b0;
		for (int i = 0; i < 7; i++) begin
			if (ops[i] == 8'h00) begin
				wp = ~wp;
				ctrl({1'b1, wp, 1'b0});
			end else
				cmd(K_WR2, CODE_LOCK_SETUP, ba, {8'h00, ops[i]});
			lk_is(exps[i]);
		end
		ctrl(3'h3);
		ctrl(3'h6);
		lk_is(2'd1);
		ctrl(3'h4);
		for (int p = 0; p < 8; p++) begin
			cmd(K_PSETUP, CODE_LOCK_SETUP, 22'h0, {5'($urandom), 3'(p), 8'($urandom)});
			cmd(K_WRRD, 8'h90, 22'h6, 16'h0);
			apb(1'b0, OFF_PS_VIEW, 32'h0);
			check(rd, {21'h0, 3'(p), 8'h00});
		end
		cmd(K_WRRD, 8'h90, 22'h0, 16'h0);
		apb(1'b0, OFF_RDATA, 32'h0);
		check(rd, {16'h0, MK});
		cmd(K_BUFPGM, CODE_BUF_PGM, ba, 16'($urandom_range(31)));
		apb(1'b0, OFF_STAT, 32'h0);
		check(rd & 32'h10, 32'h10);
		apb(1'b1, OFF_STAT, 32'h16);
		apb(1'b0, OFF_STAT, 32'h0);
		check(rd, 32'h0);
		// suspend, poll, then a resume that must reach the suspended block
		cmd(K_WR1, 8'hB0, ba, 16'h0);
		cmd(K_POLL, CODE_STATUS_READ, ba, 16'h0);
		apb(1'b0, OFF_STAT, 32'h0);
		check(rd, 32'h8);
		cmd(K_WR1, CODE_RESUME, 22'h0, 16'h0);
		check({10'h0, pins.addr}, {10'h0, ba});
		apb(1'b0, OFF_STAT, 32'h0);
		check(rd, 32'h4);
		apb(1'b1, OFF_STAT, 32'h16);
		cmd(K_WR1, 8'hC0, ba, 16'h0);
		sr_is(8'hF0);
		// a second start while busy is refused and leaves the first alone
		apb(1'b1, OFF_CMD, {21'h0, K_DATA, 8'h00});
		apb(1'b1, OFF_CMD, {21'h0, K_RD, 8'h00});
		do
			apb(1'b0, OFF_STAT, 32'h0);
		while (rd[STAT_BUSY_BIT] !== 1'b0);
		check(rd, 32'h2);
		off = 15'($urandom);
		cmd(K_RD, 8'h00, ba | {7'h0, off}, 16'h0);
		apb(1'b0, OFF_RDATA, 32'h0);
		check(rd, {16'h0, ba[15], off});
		end_sim();
	end

	// cut a hang short
	initial begin
		repeat (50000) @(posedge clk);
		err_total++;
		end_sim();
	end
endmodule
